// ### loopback_pkg.sv
/*
 * constants shared by the serial loop-back switch and its echo front end.
 * assumes a single clk_sys domain; all serial lines idle at the mark level.
 */
// Functional notes
// - local loop blocks transmit, ready, request to modem
// - local loop ignores modem receive and status lines
// - local loop routes transmit, ready, request back
// - echo mode retransmits every received character immediately
// - echo mode drives request-to-send low
`default_nettype none
package loopback_pkg;
    // serial data idles at mark; modem controls are active low, inactive high
    localparam logic LINE_MARK     = 1'h1;
    localparam logic CTRL_INACTIVE = 1'h1;
    localparam logic CTRL_ASSERTED = 1'h0;
    // reset values of every registered output
    localparam logic RST_DATA      = LINE_MARK;
    localparam logic RST_CTRL      = CTRL_INACTIVE;
    localparam logic RST_OUT_EN    = 1'h0;
endpackage
`default_nettype wire

// ### echo_path.sv
/*
 * adapter transmit front end: in echo mode the received line is sent
 * straight back out and request-to-send is held asserted.
 * assumes rx_line is already registered in clk_sys.
 */
`default_nettype none
module echo_path (
    input  wire logic echo_mode,   // command echo select
    input  wire logic rx_line,     // receive line as seen by the adapter
    input  wire logic uart_txd,    // adapter serial transmit
    input  wire logic uart_rts_n,  // adapter request to send
    output logic      tx_line,     // transmit line after echo select
    output logic      rts_n        // request to send after echo select
);
    import loopback_pkg::*;

    // bit-level echo: no character buffering, so retransmission is immediate
    assign tx_line = echo_mode ? rx_line : uart_txd;
    assign rts_n   = echo_mode ? CTRL_ASSERTED : uart_rts_n;
endmodule
`default_nettype wire

// ### serial_loopback_switch.sv
/*
 * diagnostic loop-back switch between a serial adapter and a modem.
 * assumes every input is synchronous to clk_sys; outputs are registered,
 * so each path has one cycle of latency, except the echo path, which has two.
 */
`default_nettype none
module serial_loopback_switch (
    input  wire logic clk_sys,           // system clock, 200 MHz
    input  wire logic rst,               // async reset, active high
    input  wire logic clk_en,            // freezes all state while low
    input  wire logic local_loop_enable, // local loop-back enable, high active
    input  wire logic echo_mode,         // adapter echo mode select
    input  wire logic uart_txd,          // adapter transmit data
    input  wire logic uart_dtr_n,        // adapter terminal ready
    input  wire logic uart_rts_n,        // adapter request to send
    output logic      uart_rxd,          // to adapter receive data
    output logic      uart_dcd_n,        // to adapter carrier detect
    output logic      uart_cts_n,        // to adapter clear to send
    output logic      uart_dsr_n,        // to adapter data set ready
    input  wire logic modem_rxd,         // modem receive data
    input  wire logic modem_dcd_n,       // modem carrier detect
    input  wire logic modem_cts_n,       // modem clear to send
    input  wire logic modem_dsr_n,       // modem data set ready
    output logic      modem_txd,         // to modem transmit data
    output logic      modem_dtr_n,       // to modem terminal ready
    output logic      modem_rts_n,       // to modem request to send
    output logic      modem_out_en       // high while driving modem lines
);
    import loopback_pkg::*;

    logic uart_rxd_q, uart_rxd_d;
    logic uart_dcd_n_q, uart_dcd_n_d;
    logic uart_cts_n_q, uart_cts_n_d;
    logic uart_dsr_n_q, uart_dsr_n_d;
    logic modem_txd_q, modem_txd_d;
    logic modem_dtr_n_q, modem_dtr_n_d;
    logic modem_rts_n_q, modem_rts_n_d;
    logic modem_out_en_q, modem_out_en_d;
    wire  tx_src;
    wire  rts_src;

    // echo sees the receive line the adapter sees, so the feed is registered
    echo_path u_echo (
        .echo_mode  (echo_mode),
        .rx_line    (uart_rxd_q),
        .uart_txd   (uart_txd),
        .uart_rts_n (uart_rts_n),
        .tx_line    (tx_src),
        .rts_n      (rts_src)
    );

    // modem side: idle levels and released drivers while looping locally
    assign modem_txd_d    = local_loop_enable ? LINE_MARK : tx_src;
    assign modem_dtr_n_d  = local_loop_enable ? CTRL_INACTIVE : uart_dtr_n;
    assign modem_rts_n_d  = local_loop_enable ? CTRL_INACTIVE : rts_src;
    assign modem_out_en_d = ~local_loop_enable;

    // adapter side: own outputs looped back, modem lines ignored
    assign uart_rxd_d   = local_loop_enable ? tx_src : modem_rxd;
    assign uart_dcd_n_d = local_loop_enable ? uart_dtr_n : modem_dcd_n;
    assign uart_cts_n_d = local_loop_enable ? rts_src : modem_cts_n;
    // no loop source exists for data set ready, so it reads not ready
    assign uart_dsr_n_d = local_loop_enable ? CTRL_INACTIVE : modem_dsr_n;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            uart_rxd_q     <= RST_DATA;
            uart_dcd_n_q   <= RST_CTRL;
            uart_cts_n_q   <= RST_CTRL;
            uart_dsr_n_q   <= RST_CTRL;
        end else if (clk_en) begin
            uart_rxd_q     <= uart_rxd_d;
            uart_dcd_n_q   <= uart_dcd_n_d;
            uart_cts_n_q   <= uart_cts_n_d;
            uart_dsr_n_q   <= uart_dsr_n_d;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            modem_txd_q    <= RST_DATA;
            modem_dtr_n_q  <= RST_CTRL;
            modem_rts_n_q  <= RST_CTRL;
            modem_out_en_q <= RST_OUT_EN;
        end else if (clk_en) begin
            modem_txd_q    <= modem_txd_d;
            modem_dtr_n_q  <= modem_dtr_n_d;
            modem_rts_n_q  <= modem_rts_n_d;
            modem_out_en_q <= modem_out_en_d;
        end
    end

    assign uart_rxd     = uart_rxd_q;
    assign uart_dcd_n   = uart_dcd_n_q;
    assign uart_cts_n   = uart_cts_n_q;
    assign uart_dsr_n   = uart_dsr_n_q;
    assign modem_txd    = modem_txd_q;
    assign modem_dtr_n  = modem_dtr_n_q;
    assign modem_rts_n  = modem_rts_n_q;
    assign modem_out_en = modem_out_en_q;
endmodule
`default_nettype wire

// ### serial_loopback_switch_chk.sv
/* checker for serial_loopback_switch: port-level relations of the loop switch.
   assumes one clk_sys domain, rst async active high, bound to every instance. */
`default_nettype none
module serial_loopback_switch_chk (
    input wire logic clk_sys, rst, clk_en, local_loop_enable, echo_mode, uart_txd, uart_dtr_n, uart_rts_n,
    input wire logic uart_rxd, uart_dcd_n, uart_cts_n, uart_dsr_n, modem_rxd, modem_dcd_n, modem_cts_n,
    input wire logic modem_dsr_n, modem_txd, modem_dtr_n, modem_rts_n, modem_out_en
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    wire on_loop = clk_en && local_loop_enable;
    wire on_pass = clk_en && !local_loop_enable;
    property p_block; on_loop |=> modem_txd && modem_dtr_n && modem_rts_n && !modem_out_en; endproperty
    a_block: assert property (p_block) else $error("modem side not idle in loop");
    property p_ignore; on_loop |=> uart_dsr_n; endproperty
    a_ignore: assert property (p_ignore) else $error("modem status leaked in loop");
    // in echo the adapter resends its own receive line, so a local loop then holds that line
    property p_route; on_loop |=> uart_rxd == ($past(echo_mode) ? $past(uart_rxd) : $past(uart_txd))
        && uart_dcd_n == $past(uart_dtr_n) && uart_cts_n == (!$past(echo_mode) && $past(uart_rts_n)); endproperty
    a_route: assert property (p_route) else $error("loop routing wrong");
    property p_pass; on_pass |=> modem_out_en && uart_rxd == $past(modem_rxd) && uart_cts_n == $past(modem_cts_n)
        && uart_dsr_n == $past(modem_dsr_n) && modem_dtr_n == $past(uart_dtr_n); endproperty
    a_pass: assert property (p_pass) else $error("pass-through wrong");
    property p_echo; on_pass && echo_mode |=> modem_txd == $past(uart_rxd); endproperty
    a_echo: assert property (p_echo) else $error("echo not retransmitted");
    property p_rts; clk_en && echo_mode |=> !($past(local_loop_enable) ? uart_cts_n : modem_rts_n); endproperty
    a_rts: assert property (p_rts) else $error("request not low in echo");
endmodule
bind serial_loopback_switch serial_loopback_switch_chk chk (.*);
`default_nettype wire

// ### modem_model.sv
/* far-side modem: puts the bench's chosen levels on the modem lines.
   assumes the bench changes drive just after a clk_sys edge. */
`default_nettype none
module modem_model (
    input  wire logic [3:0] drive, // receive, carrier, clear, ready
    output logic            modem_rxd, modem_dcd_n, modem_cts_n, modem_dsr_n
);
    assign {modem_rxd, modem_dcd_n, modem_cts_n, modem_dsr_n} = drive;
endmodule
`default_nettype wire

// ### serial_loopback_switch_test.sv
/* bench: walks all 1024 input patterns, one per cycle, against a reference,
   then sends one framed character from the modem in remote loop-back.
   assumes one-cycle registered outputs and clk_en freezing all state. */
`default_nettype none
module serial_loopback_switch_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 0, rst = 1;
    logic [9:0] v = '0, vp;
    logic [7:0] e = 8'hfe;
    int fails = 0, checks_done = 0, cyc = 0;
    // adapter set-up for remote loop-back; only the echo select reaches this block
    localparam logic [7:0]  REMOTE_CTRL = 8'h10;   // receiver clocked like transmitter
    localparam logic [7:0]  REMOTE_CMD  = 8'h18;   // echo on, tx and rx interrupts off
    localparam logic [11:0] ECHO_FRAME  = 12'heb4; // start, 8'h5a lsb first, stop, idle mark
    wire remote_ready = REMOTE_CTRL[4] && REMOTE_CMD[4:1] == 4'hc;
    wire clk_en, local_loop_enable, echo_mode, uart_txd, uart_dtr_n, uart_rts_n, uart_rxd, uart_dcd_n, uart_cts_n;
    wire uart_dsr_n, modem_rxd, modem_dcd_n, modem_cts_n, modem_dsr_n, modem_txd, modem_dtr_n, modem_rts_n, modem_out_en;
    wire [7:0] o = {uart_rxd, uart_dcd_n, uart_cts_n, uart_dsr_n, modem_txd, modem_dtr_n, modem_rts_n, modem_out_en};
    assign {local_loop_enable, echo_mode, uart_txd, uart_dtr_n, uart_rts_n, clk_en} = {v[9:5], v[0]};
    serial_loopback_switch dut (.*);
    modem_model far (.drive(v[4:1]), .*);
    initial forever #2.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (++cyc > 1200) begin
        fails++;
        print_verdict();
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        if (fails == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk_sys);
        check(o, 8'hfe);
        rst <= 0;
        for (int i = 0; i <= 1024; i++) begin
            @(posedge clk_sys);
            vp = v;
            v <= i[9:0];
            #1;
            // echo resends the registered receive line, so it reuses the previous expectation
            if (vp[0]) e = vp[9] ? {vp[8] ? e[7] : vp[7], vp[6], vp[5] & ~vp[8], 5'h1e}
                               : {vp[4:1], vp[8] ? e[7] : vp[7], vp[6], vp[5] & ~vp[8], 1'h1};
            if (i > 0) check(o, e);
        end
        // remote loop-back: adapter's own transmit held at space, so only the echo can reach the modem
        for (int b = 0; b < 12; b++) begin
            @(posedge clk_sys);
            v <= {1'h0, remote_ready, 3'h0, ECHO_FRAME[b], 3'h0, 1'h1};
            #1;
            if (b >= 1) check({4'h0, uart_rxd, uart_dcd_n, uart_cts_n, uart_dsr_n}, {4'h0, ECHO_FRAME[b - 1], 3'h0});
            if (b >= 2) check({5'h0, modem_txd, modem_rts_n, modem_out_en}, {5'h0, ECHO_FRAME[b - 2], 2'h1});
        end
        print_verdict();
    end
endmodule
`default_nettype wire
